// >>> test/serial_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(parameter int BIT_CLKS = 32) (
  input wire logic clk, // core clock
  output logic line // serial line, marking high
);
  initial line = 1'b1;
  // lsb first; always returns the line to marking so no stray start follows
  task automatic send(input logic [19:0] frame, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      line <= frame[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test/uart_rx_line_status_props.sv
// bus-side checker for the receive line status block
`timescale 1ns/1ps
`default_nettype none
module uart_rx_ls_props (
  input wire logic clk, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic [31:0] address, // bus address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [31:0] writedata, // write data
  input wire logic [31:0] readdata, // read data
  input wire logic waitrequest, // stall
  input wire logic serial_rx_input, // serial line
  input wire logic irq // interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  rd_wait_a: assert property ($rose(read) |-> one_wait)
    else $error("read stall not one cycle");
  wr_wait_a: assert property ($rose(write) |-> one_wait)
    else $error("write stall not one cycle");
  idle_wait_a: assert property (!read && !write |-> !waitrequest)
    else $error("stall while idle");
  wait_req_a: assert property (waitrequest |-> read || write)
    else $error("stall without request");
  lsr_high_a: assert property (read && !waitrequest && address == 32'h40008014
    |-> readdata[31:5] == 27'h0) else $error("status upper bits set");
  unmap_zero_a: assert property (read && !waitrequest && address == 32'h40008030
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(read) |-> $stable(readdata))
    else $error("read data moved without read");
  irq_rst_a: assert property ($rose(rst_n) |-> !irq)
    else $error("interrupt after reset");
endmodule
bind uart_rx_line_status uart_rx_ls_props i_props (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .serial_rx_input(serial_rx_input), .irq(irq));
`default_nettype wire

// >>> test/uart_rx_line_status_tb_top.sv
// testbench for the receive line status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_consts.svh"
module uart_rx_line_status_tb_top;
  localparam logic [31:0] UNMAPPED = 32'h40008030;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] address = 32'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic rx_line;
  int mismatches = 0;
  int total_checks = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  uart_rx_line_status i_uart_rx_line_status (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .serial_rx_input(rx_line), .irq(irq));
  serial_tx_model i_serial_tx_model (.clk(clk), .line(rx_line));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // idle edge at the end keeps back-to-back calls from assigning twice in one step
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) mismatches++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    total_checks++;
    if (q !== exp) begin
      mismatches++;
      $display("wrong value reg %h exp %h got %h", a, exp, q);
    end
  endtask
  task automatic chk_irq(input logic exp);
    total_checks++;
    if (irq !== exp) begin
      mismatches++;
      $display("wrong value irq exp %b got %b", exp, irq);
    end
  endtask
  function automatic logic [19:0] frm(input logic [7:0] d, input logic stp);
    return {10'h0, stp, d, 1'b0};
  endfunction
  initial begin
    logic [3:0] pv;
    pv = 4'b0101;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(`LSR_ADDR, 32'h0);
    chk(`CFG_ADDR, 32'h03);
    chk(`DIV_ADDR, 32'h01);
    chk(UNMAPPED, 32'h0);
    wr(`LSR_ADDR, 32'hFF);
    chk(`LSR_ADDR, 32'h0);
    i_serial_tx_model.send(frm(8'h5A, 1'b1), 10);
    chk_irq(1'b0);
    wr(`IMASK_ADDR, 32'h1);
    chk_irq(1'b1);
    chk(`ISTAT_ADDR, 32'h1);
    chk_irq(1'b0);
    chk(`LSR_ADDR, 32'h1);
    chk(`RBR_ADDR, 32'h5A);
    chk(`LSR_ADDR, 32'h0);
    i_serial_tx_model.send(frm(8'h11, 1'b1), 10);
    i_serial_tx_model.send(frm(8'h22, 1'b1), 10);
    chk(`LSR_ADDR, 32'h3);
    chk(`RBR_ADDR, 32'h11);
    chk(`LSR_ADDR, 32'h0);
    i_serial_tx_model.send(frm(8'hA5, 1'b0), 10);
    chk(`LSR_ADDR, 32'h9);
    chk(`RBR_ADDR, 32'hA5);
    // low stop acts as a start, so all-high bits after it form 0xFF
    repeat (400) @(posedge clk);
    chk(`LSR_ADDR, 32'h1);
    chk(`RBR_ADDR, 32'hFF);
    for (int m = 0; m < 4; m++) begin
      wr(`CFG_ADDR, 32'h0B | (32'(m) << 4));
      i_serial_tx_model.send({9'h0, 1'b1, ~pv[m], 8'h03, 1'b0}, 11);
      chk(`LSR_ADDR, 32'h5);
      chk(`RBR_ADDR, 32'h03);
    end
    wr(`CFG_ADDR, 32'h5B);
    i_serial_tx_model.send({9'h0, 1'b1, 1'b1, 8'h01, 1'b0}, 11);
    i_serial_tx_model.send({9'h0, 1'b1, 1'b0, 8'h02, 1'b0}, 11);
    chk(`LSR_ADDR, 32'h1);
    chk(`RBR_ADDR, 32'h01);
    chk(`LSR_ADDR, 32'h5);
    chk(`RBR_ADDR, 32'h02);
    i_serial_tx_model.send(20'h0, 20);
    chk(`LSR_ADDR, 32'h11);
    chk(`RBR_ADDR, 32'h00);
    chk(`LSR_ADDR, 32'h0);
    // every event kind has fired since the one early interrupt status read
    chk(`ISTAT_ADDR, 32'h1F);
    // five-bit characters land right aligned in the buffer
    wr(`CFG_ADDR, 32'h40);
    i_serial_tx_model.send({13'h0, 1'b1, 5'h15, 1'b0}, 7);
    chk_irq(1'b1);
    chk(`LSR_ADDR, 32'h1);
    chk(`RBR_ADDR, 32'h15);
    end_of_test();
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verilog/rx_char_fifo.sv
// receive character fifo: data byte plus per-character error bits
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_consts.svh"
module rx_char_fifo (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic push, // store push_data
  input wire uart_rx_pkg::rx_entry_t push_data, // character with error bits
  input wire logic pop, // drop the head entry
  input wire logic flush, // empty the fifo
  output uart_rx_pkg::rx_entry_t head_data, // entry at the head
  output logic empty, // no entry stored
  output logic full // all entries used
);
  import uart_rx_pkg::*;

  rx_entry_t mem_ff [`FIFO_DEPTH];
  rx_entry_t nxt_mem [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [`FIFO_AW:0] count_ff, nxt_count;
  logic do_push, do_pop;

  assign empty = (count_ff == '0);
  assign full = (count_ff == (`FIFO_AW+1)'(`FIFO_DEPTH));
  assign head_data = mem_ff[rd_ptr_ff];
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  genvar i;
  generate
    for (i = 0; i < `FIFO_DEPTH; i++) begin : g_ent
      always_comb begin
        nxt_mem[i] = mem_ff[i];
        if (do_push && wr_ptr_ff == (`FIFO_AW)'(i)) begin
          nxt_mem[i] = push_data;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[i] <= '0;
        end else begin
          mem_ff[i] <= nxt_mem[i];
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff + (`FIFO_AW)'(do_push);
    nxt_rd_ptr = rd_ptr_ff + (`FIFO_AW)'(do_pop);
    nxt_count = count_ff + (`FIFO_AW+1)'(do_push) - (`FIFO_AW+1)'(do_pop);
    if (flush) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/uart_rx_consts.svh
// constant macros for the receive line status block
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

`define RBR_ADDR 32'h40008000
`define CFG_ADDR 32'h40008010
`define LSR_ADDR 32'h40008014
`define DIV_ADDR 32'h40008018
`define ISTAT_ADDR 32'h40008020
`define IMASK_ADDR 32'h40008024

`define LSR_READY 0
`define LSR_OE 1
`define LSR_PERR 2
`define LSR_FERR 3
`define LSR_BRK 4

`define CFG_WLS_LO 0
`define CFG_WLS_HI 1
`define CFG_PEN 3
`define CFG_PS_LO 4
`define CFG_PS_HI 5
`define CFG_FEN 6
`define CFG_RESET 8'h03
`define DIV_RESET 16'h0001

`define ENT_PERR 8
`define ENT_FERR 9
`define ENT_BRK 10
`define ENT_W 11
`define FIFO_DEPTH 16
`define FIFO_AW 4

`define TICK_LAST 4'hF
`define TICK_MID 4'h7
`define BIT_BASE 3'h4
`define ALIGN_MAX 2'h3
`define PS_ODD 2'h0
`define PS_EVEN 2'h1
`define PS_ONE 2'h2

`endif

// >>> verilog/uart_rx_line_status.sv
// uart receiver with line status register behind an avalon-mm slave
// How it works
// (RULE_01) data ready while receive buffer not empty
// (RULE_02) overrun sets at once, cleared by status read
// (RULE_03) full fifo: keep contents, drop new character
// (RULE_04) parity error flag, cleared by status read
// (RULE_05) parity error follows the fifo head character
// (RULE_06) low stop bit sets framing error flag
// (RULE_07) bad stop bit taken as early start
// (RULE_08) framing error follows the fifo head character
// (RULE_09) line low whole character signals break
// (RULE_10) after break, idle until line goes high
// (RULE_11) break flag cleared by status read
// (RULE_12) status register read only, writes ignored
// (RULE_13) clear on read spares events after capture
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_consts.svh"
module uart_rx_line_status (
  input wire logic clk, // 250 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [31:0] address, // avalon byte address
  input wire logic read, // avalon read request
  input wire logic write, // avalon write request
  input wire logic [31:0] writedata, // avalon write data
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon stall
  input wire logic serial_rx_input, // serial receive pin
  output logic irq // level interrupt
);
  import uart_rx_pkg::*;

  // ---------------- bus slave ----------------
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req, done, rd_done, wr_done;
  logic [7:0] cfg_ff, nxt_cfg;
  logic [15:0] div_ff, nxt_div;
  logic [4:0] imask_ff, nxt_imask;
  logic [4:0] istat_ff, nxt_istat;
  logic [4:0] lsr_err;
  logic oe_ff, perr_ff, ferr_ff, brk_ff;
  logic nxt_oe, nxt_perr, nxt_ferr, nxt_brk;
  logic head_seen_ff, nxt_head_seen;
  rx_entry_t head;
  logic fifo_empty, fifo_full, eff_full, flush;
  logic push, pop;
  rx_entry_t push_data;

  assign req = read | write;
  // one wait cycle gives time to register the read data
  assign waitrequest = req & ~ack_ff;
  assign done = req & ack_ff;
  assign rd_done = done & read;
  assign wr_done = done & write;
  assign readdata = rdata_ff;
  assign lsr_err = {brk_ff, ferr_ff, perr_ff, oe_ff, ~fifo_empty}; // RULE_01

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (read && !ack_ff) begin
      nxt_rdata = '0;
      unique case (address)
        `RBR_ADDR: nxt_rdata = {24'h000000, head[7:0]};
        `CFG_ADDR: nxt_rdata = {24'h000000, cfg_ff};
        `LSR_ADDR: nxt_rdata = {27'h0000000, lsr_err};
        `DIV_ADDR: nxt_rdata = {16'h0000, div_ff};
        `ISTAT_ADDR: nxt_rdata = {27'h0000000, istat_ff};
        `IMASK_ADDR: nxt_rdata = {27'h0000000, imask_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------- configuration ----------------
  // the line status address has no write path at all
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_div = div_ff;
    nxt_imask = imask_ff;
    flush = 1'b0;
    if (wr_done && address == `CFG_ADDR) begin
      nxt_cfg = writedata[7:0];
      flush = writedata[`CFG_FEN] ^ cfg_ff[`CFG_FEN];
    end
    if (wr_done && address == `DIV_ADDR) begin
      nxt_div = writedata[15:0];
    end
    if (wr_done && address == `IMASK_ADDR) begin
      nxt_imask = writedata[4:0];
    end
  end // RULE_12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= `CFG_RESET;
      div_ff <= `DIV_RESET;
      imask_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
      div_ff <= nxt_div;
      imask_ff <= nxt_imask;
    end
  end

  // ---------------- line sync and 16x tick ----------------
  logic rx_meta_ff, rx_s_ff;
  logic [15:0] div_cnt_ff, nxt_div_cnt;
  logic s_tick;

  assign s_tick = (div_cnt_ff == '0);

  always_comb begin
    nxt_div_cnt = s_tick ? div_ff : div_cnt_ff - 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_ff <= 1'b1;
      rx_s_ff <= 1'b1;
      div_cnt_ff <= '0;
    end else begin
      rx_meta_ff <= serial_rx_input;
      rx_s_ff <= rx_meta_ff;
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // ---------------- receive shift machine ----------------
  rx_state_e state_ff, nxt_state;
  logic [3:0] tick_ff, nxt_tick;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic zero_ff, nxt_zero;
  logic par_ff, nxt_par;
  logic [2:0] last_bit;
  logic [7:0] aligned;
  logic par_bad, bit_end;

  assign last_bit = `BIT_BASE + {1'b0, cfg_ff[`CFG_WLS_HI:`CFG_WLS_LO]};
  assign aligned = shift_ff >> (`ALIGN_MAX - cfg_ff[`CFG_WLS_HI:`CFG_WLS_LO]);
  assign bit_end = s_tick && tick_ff == `TICK_LAST;

  always_comb begin
    unique case (cfg_ff[`CFG_PS_HI:`CFG_PS_LO])
      `PS_ODD: par_bad = ~(^aligned ^ par_ff);
      `PS_EVEN: par_bad = ^aligned ^ par_ff;
      `PS_ONE: par_bad = ~par_ff;
      default: par_bad = par_ff;
    endcase
    par_bad = par_bad & cfg_ff[`CFG_PEN];
  end // RULE_04

  always_comb begin
    nxt_state = state_ff;
    nxt_tick = tick_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_zero = zero_ff;
    nxt_par = par_ff;
    push = 1'b0;
    push_data = '0;
    if (s_tick) begin
      nxt_tick = tick_ff + 4'h1;
    end
    unique case (state_ff)
      RX_IDLE: begin
        nxt_tick = '0;
        if (!rx_s_ff) begin
          nxt_state = RX_START;
        end
      end
      RX_START: begin
        if (s_tick && tick_ff == `TICK_MID) begin
          nxt_tick = '0;
          nxt_bit = '0;
          nxt_zero = 1'b1;
          nxt_par = 1'b0;
          nxt_state = rx_s_ff ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (bit_end) begin
          nxt_shift = {rx_s_ff, shift_ff[7:1]};
          nxt_zero = zero_ff & ~rx_s_ff;
          nxt_bit = bit_ff + 3'h1;
          if (bit_ff == last_bit) begin
            nxt_state = cfg_ff[`CFG_PEN] ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (bit_end) begin
          nxt_par = rx_s_ff;
          nxt_zero = zero_ff & ~rx_s_ff;
          nxt_state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          push = 1'b1;
          push_data = {1'b0, 1'b0, par_bad, aligned};
          if (!rx_s_ff && zero_ff) begin
            push_data = '0;
            push_data[`ENT_BRK] = 1'b1; // RULE_09
            nxt_state = RX_BREAK;
          end else if (!rx_s_ff) begin
            push_data[`ENT_FERR] = 1'b1; // RULE_06
            // the low stop bit already counts as a checked start bit
            nxt_bit = '0;
            nxt_zero = 1'b1;
            nxt_par = 1'b0;
            nxt_state = RX_DATA; // RULE_07
          end else begin
            nxt_state = RX_IDLE;
          end
        end
      end
      RX_BREAK: begin
        if (rx_s_ff) begin
          nxt_state = RX_IDLE; // RULE_10
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RX_IDLE;
      tick_ff <= '0;
      bit_ff <= '0;
      shift_ff <= '0;
      zero_ff <= 1'b1;
      par_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tick_ff <= nxt_tick;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      zero_ff <= nxt_zero;
      par_ff <= nxt_par;
    end
  end

  // ---------------- receive buffer ----------------
  // with the fifo disabled the buffer holds a single character
  assign eff_full = cfg_ff[`CFG_FEN] ? fifo_full : ~fifo_empty;
  assign pop = rd_done && address == `RBR_ADDR;

  rx_char_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(push & ~eff_full), // RULE_03
    .push_data(push_data),
    .pop(pop),
    .flush(flush),
    .head_data(head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // ---------------- line status flags ----------------
  logic lsr_rd, ist_rd, ovr_evt, head_new;
  logic [4:0] evt;

  assign lsr_rd = rd_done && address == `LSR_ADDR;
  assign ist_rd = rd_done && address == `ISTAT_ADDR;
  assign ovr_evt = push & eff_full; // RULE_03
  // error bits are raised as the character reaches the head
  assign head_new = ~fifo_empty & ~head_seen_ff & ~flush;

  always_comb begin
    nxt_head_seen = (head_seen_ff | head_new) & ~pop & ~flush;
    // only bits the master actually saw are cleared; a new set wins
    nxt_oe = (oe_ff & ~(lsr_rd & rdata_ff[`LSR_OE])) | ovr_evt; // RULE_02 RULE_13
    nxt_perr = (perr_ff & ~(lsr_rd & rdata_ff[`LSR_PERR]))
               | (head_new & head[`ENT_PERR]); // RULE_05
    nxt_ferr = (ferr_ff & ~(lsr_rd & rdata_ff[`LSR_FERR]))
               | (head_new & head[`ENT_FERR]); // RULE_08
    nxt_brk = (brk_ff & ~(lsr_rd & rdata_ff[`LSR_BRK])) | (head_new & head[`ENT_BRK]); // RULE_11
    evt = {head_new & head[`ENT_BRK], head_new & head[`ENT_FERR], head_new & head[`ENT_PERR],
           ovr_evt, push & ~eff_full};
    nxt_istat = (istat_ff & ~({5{ist_rd}} & rdata_ff[4:0])) | evt; // RULE_13
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_seen_ff <= 1'b0;
      oe_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      brk_ff <= 1'b0;
      istat_ff <= '0;
    end else begin
      head_seen_ff <= nxt_head_seen;
      oe_ff <= nxt_oe;
      perr_ff <= nxt_perr;
      ferr_ff <= nxt_ferr;
      brk_ff <= nxt_brk;
      istat_ff <= nxt_istat;
    end
  end

  assign irq = |(istat_ff & imask_ff);
endmodule
`default_nettype wire

// >>> verilog/uart_rx_pkg.sv
// types shared by the receive line status block
package uart_rx_pkg;
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP,
    RX_BREAK
  } rx_state_e;
  typedef logic [10:0] rx_entry_t;
endpackage
